/* pkg/tgate_pkg.sv */
/*
 Package for the time gate controller: register map, field layout,
 reset values, mode encodings and carrier structs.
 Assumes a 32-bit classic Wishbone register bus and a 20 MHz clock.
*/
package tgate_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DELAY   = 8'h04;
  localparam logic [7:0] OFS_LENGTH  = 8'h08;
  localparam logic [7:0] OFS_HOLDOFF = 8'h0C;
  localparam logic [7:0] OFS_CAPLEN  = 8'h10;
  localparam logic [7:0] OFS_POINTS  = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_RAMPSTEP = 8'h1C;

  // Control field positions
  localparam int CTRL_EDGE_BIT    = 0;
  localparam int CTRL_HOLD_EN_BIT = 1;
  localparam int CTRL_METHOD_LSB  = 2;
  localparam int CTRL_ENABLE_BIT  = 4;

  // Gating methods
  localparam logic [1:0] METHOD_FFT   = 2'h0;
  localparam logic [1:0] METHOD_LO    = 2'h1;
  localparam logic [1:0] METHOD_VIDEO = 2'h2;

  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] DELAY_RST   = 32'h0000_0001;
  localparam logic [31:0] LENGTH_RST  = 32'h0000_0001;
  localparam logic [31:0] HOLDOFF_RST = 32'h0000_0000;
  localparam logic [31:0] CAPLEN_RST  = 32'h0000_0001;
  localparam logic [15:0] POINTS_RST  = 16'h0191;
  localparam logic [31:0] STEP_RST    = 32'h0000_0001;

  // Capture time is this factor (x100) over the filter width
  localparam int CAP_FACTOR_X100 = 183;
  localparam int CLK_HZ          = 20_000_000;

  localparam logic [15:0] VIDEO_MIN = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_OPEN  = 4'b0100,
    ST_HOLD  = 4'b1000
  } gate_state_t;

  typedef struct packed {
    logic        edge_mode;
    logic        holdoff_en;
    logic [1:0]  method;
    logic        enable;
    logic [31:0] delay;
    logic [31:0] length;
    logic [31:0] holdoff;
    logic [31:0] caplen;
    logic [15:0] points;
    logic [31:0] ramp_step;
  } cfg_t;

  typedef struct packed {
    logic [15:0] video;
    logic [15:0] peak;
    logic        point_done;
  } video_t;

endpackage : tgate_pkg

/* rtl/time_gate_controller.sv */
/*
 Time gate controller: gate window from an external trigger, applied to
 gated FFT capture, a frozen LO sweep ramp, or blanked peak-held video.
 Assumes a classic Wishbone master on mclk and an asynchronous trigger pin.
*/
// The register offsets and the Wishbone interface to the registers were decided locally.
// Behaviour
// R1: Gate timing comes from external trigger input
// R2: Selectable edge or level trigger mode
// R3: Optional holdoff ignores triggers after window
// R4: Programmable delay from trigger to gate
// R5: Programmable length keeps gate open
// R6: Level mode gates while trigger high
// R7: Edge mode window from edge, delay, length
// R8: Software picks window avoiding burst edges
// R9: FFT capture starts after delay, 1.83/width
// R10: One transform per completed capture
// R11: LO ramp advances only while gate open
// R12: LO ramp holds value while gate blocked
// R13: Video forced to minimum while blocked
// R14: Video peak held per display point
// R15: Sweep time covers points times burst cycle
// R16: Display points default to 401
// R17: Down-counters, blocked at reset, busy ignores triggers
// R18: Method select applies gate to one path
`timescale 1ns/1ns
`default_nettype none
module time_gate_controller
  import tgate_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External gate trigger pin
  input  wire logic        gate_trig,
  // Video path in and out
  input  wire logic [15:0] video_in,
  input  wire logic        point_tick,
  output logic      [15:0] video_out,
  output logic      [15:0] point_peak,
  output logic             point_valid,
  // Gated FFT capture
  output logic             capture_active,
  output logic             fft_start,
  input  wire logic        fft_busy,
  // LO sweep ramp
  output logic      [31:0] lo_ramp,
  input  wire logic        sweep_restart,
  // Gate status
  output logic             gate_open
);

  typedef struct packed {
    logic [2:0]  trig_sync;
    logic        trig_lvl;
    cfg_t        cfg;
    gate_state_t st;
    logic [31:0] cnt;
    logic [31:0] capcnt;
    logic        capturing;
    logic        fft_go;
    logic        cap_pend;
    logic [31:0] ramp;
    video_t      vid;
    logic [15:0] pt_cnt;
    logic        peak_seen;
    logic        gate;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] trig_count;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;

  logic        wb_req;
  logic        trig_rise;
  logic [31:0] wmask;
  logic        gate_now;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_wr;
  logic [31:0] pts_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~cur_ff.ack;

  // Byte-lane write mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // R1 synchronised trigger
  assign trig_rise = cur_ff.trig_sync[2] & cur_ff.trig_sync[1] & ~cur_ff.trig_lvl;

  // R6 level mode direct gate
  assign gate_now = cur_ff.cfg.enable &
                    (cur_ff.cfg.edge_mode ? (cur_ff.st == ST_OPEN) : cur_ff.trig_lvl);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Control word as read; lanes merged before fields are picked out
  assign ctrl_rd = {27'h0, cur_ff.cfg.enable, cur_ff.cfg.method,
                    cur_ff.cfg.holdoff_en, cur_ff.cfg.edge_mode};
  assign ctrl_wr = merge(ctrl_rd, wb_dat_i, wmask);
  assign pts_wr  = merge({16'h0, cur_ff.cfg.points}, wb_dat_i, wmask);

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.trig_sync = {cur_ff.trig_sync[1:0], gate_trig};
    // Change level only once stages two and three agree
    if (cur_ff.trig_sync[2] == cur_ff.trig_sync[1]) begin
      nxt_ff.trig_lvl = cur_ff.trig_sync[2];
    end
    nxt_ff.fft_go = 1'b0;
    nxt_ff.vid.point_done = 1'b0;
    nxt_ff.ack = 1'b0;

    // R2 edge mode machine
    case (cur_ff.st)
      ST_IDLE: begin
        // R7 edge opens window
        if (cur_ff.cfg.enable && cur_ff.cfg.edge_mode && trig_rise) begin
          nxt_ff.trig_count = cur_ff.trig_count + 16'h0001;
          // R4 delay down-count
          if (cur_ff.cfg.delay == 32'h0000_0000) begin
            nxt_ff.st  = ST_OPEN;
            nxt_ff.cnt = cur_ff.cfg.length;
          end else begin
            nxt_ff.st  = ST_DELAY;
            nxt_ff.cnt = cur_ff.cfg.delay;
          end
        end
      end
      // R17 triggers ignored while busy
      ST_DELAY: begin
        if (cur_ff.cnt <= 32'h0000_0001) begin
          nxt_ff.st  = ST_OPEN;
          nxt_ff.cnt = cur_ff.cfg.length;
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 32'h0000_0001;
        end
      end
      // R5 length down-count
      ST_OPEN: begin
        if (cur_ff.cnt <= 32'h0000_0001) begin
          // R3 optional holdoff
          if (cur_ff.cfg.holdoff_en && cur_ff.cfg.holdoff != 32'h0000_0000) begin
            nxt_ff.st  = ST_HOLD;
            nxt_ff.cnt = cur_ff.cfg.holdoff;
          end else begin
            nxt_ff.st = ST_IDLE;
          end
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 32'h0000_0001;
        end
      end
      ST_HOLD: begin
        if (cur_ff.cnt <= 32'h0000_0001) begin
          nxt_ff.st = ST_IDLE;
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 32'h0000_0001;
        end
      end
      default: begin
        nxt_ff.st = ST_IDLE;
      end
    endcase
    if (!cur_ff.cfg.enable || !cur_ff.cfg.edge_mode) begin
      nxt_ff.st = ST_IDLE;
    end
    nxt_ff.gate = gate_now;

    // R9 FFT capture at gate open
    if (cur_ff.cfg.method == METHOD_FFT) begin
      if (!cur_ff.capturing && gate_now && !cur_ff.gate && !cur_ff.cap_pend) begin
        nxt_ff.capturing = 1'b1;
        nxt_ff.capcnt    = cur_ff.cfg.caplen;
      end else if (cur_ff.capturing) begin
        if (cur_ff.capcnt <= 32'h0000_0001) begin
          nxt_ff.capturing = 1'b0;
          nxt_ff.cap_pend  = 1'b1;
        end else begin
          nxt_ff.capcnt = cur_ff.capcnt - 32'h0000_0001;
        end
      end
    end else begin
      nxt_ff.capturing = 1'b0;
    end
    // R10 one transform per capture
    if (cur_ff.cap_pend && !fft_busy) begin
      nxt_ff.cap_pend = 1'b0;
      nxt_ff.fft_go   = 1'b1;
    end

    // R11 ramp advances while open
    if (sweep_restart) begin
      nxt_ff.ramp = 32'h0000_0000;
    end else if (cur_ff.cfg.method == METHOD_LO && gate_now) begin
      nxt_ff.ramp = cur_ff.ramp + cur_ff.cfg.ramp_step;
    end
    // R12 otherwise ramp holds

    // R13 blank video when blocked
    if (cur_ff.cfg.method == METHOD_VIDEO && !gate_now) begin
      nxt_ff.vid.video = VIDEO_MIN;
    end else begin
      nxt_ff.vid.video = video_in;
    end
    // R14 peak detect per point
    if (cur_ff.cfg.method == METHOD_VIDEO) begin
      if (point_tick) begin
        nxt_ff.vid.point_done = 1'b1;
        nxt_ff.pt_cnt = (cur_ff.pt_cnt + 16'h0001 >= cur_ff.cfg.points) ?
                        16'h0000 : cur_ff.pt_cnt + 16'h0001;
        nxt_ff.peak_seen = 1'b0;
        nxt_ff.vid.peak  = VIDEO_MIN;
      end else if (nxt_ff.vid.video > cur_ff.vid.peak || !cur_ff.peak_seen) begin
        nxt_ff.vid.peak  = nxt_ff.vid.video;
        nxt_ff.peak_seen = 1'b1;
      end
    end

    // Register bus; one-cycle ack
    if (wb_req) begin
      nxt_ff.ack = 1'b1;
      nxt_ff.rdata = 32'h0000_0000;
      if (wb_adr_i == OFS_CTRL) begin
        nxt_ff.rdata = ctrl_rd;
        if (wb_we_i) begin
          // R18 method select
          nxt_ff.cfg.edge_mode  = ctrl_wr[CTRL_EDGE_BIT];
          nxt_ff.cfg.holdoff_en = ctrl_wr[CTRL_HOLD_EN_BIT];
          nxt_ff.cfg.method     = ctrl_wr[CTRL_METHOD_LSB +: 2];
          nxt_ff.cfg.enable     = ctrl_wr[CTRL_ENABLE_BIT];
        end
      end else if (wb_adr_i == OFS_DELAY) begin
        nxt_ff.rdata = cur_ff.cfg.delay;
        if (wb_we_i) nxt_ff.cfg.delay = merge(cur_ff.cfg.delay, wb_dat_i, wmask);
      end else if (wb_adr_i == OFS_LENGTH) begin
        nxt_ff.rdata = cur_ff.cfg.length;
        if (wb_we_i) nxt_ff.cfg.length = merge(cur_ff.cfg.length, wb_dat_i, wmask);
      end else if (wb_adr_i == OFS_HOLDOFF) begin
        nxt_ff.rdata = cur_ff.cfg.holdoff;
        if (wb_we_i) nxt_ff.cfg.holdoff = merge(cur_ff.cfg.holdoff, wb_dat_i, wmask);
      end else if (wb_adr_i == OFS_CAPLEN) begin
        nxt_ff.rdata = cur_ff.cfg.caplen;
        if (wb_we_i) nxt_ff.cfg.caplen = merge(cur_ff.cfg.caplen, wb_dat_i, wmask);
      end else if (wb_adr_i == OFS_POINTS) begin
        // Upper half shows the display point index, read only
        nxt_ff.rdata = {cur_ff.pt_cnt, cur_ff.cfg.points};
        if (wb_we_i) begin
          nxt_ff.cfg.points = pts_wr[15:0];
        end
      end else if (wb_adr_i == OFS_STATUS) begin
        nxt_ff.rdata = {cur_ff.trig_count, 4'h0, cur_ff.st, 5'h0,
                        cur_ff.cap_pend, cur_ff.capturing, cur_ff.gate};
      end else if (wb_adr_i == OFS_RAMPSTEP) begin
        nxt_ff.rdata = cur_ff.cfg.ramp_step;
        if (wb_we_i) nxt_ff.cfg.ramp_step = merge(cur_ff.cfg.ramp_step, wb_dat_i, wmask);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // R17 gate blocked at reset
      cur_ff <= '{trig_sync: 3'h0, trig_lvl: 1'b0,
                  cfg: '{edge_mode: CTRL_RST[CTRL_EDGE_BIT],
                         holdoff_en: CTRL_RST[CTRL_HOLD_EN_BIT],
                         method: CTRL_RST[CTRL_METHOD_LSB +: 2],
                         enable: CTRL_RST[CTRL_ENABLE_BIT],
                         delay: DELAY_RST, length: LENGTH_RST,
                         holdoff: HOLDOFF_RST, caplen: CAPLEN_RST,
                         // R16 default 401 points
                         points: POINTS_RST, ramp_step: STEP_RST},
                  st: ST_IDLE, cnt: 32'h0, capcnt: 32'h0, capturing: 1'b0,
                  fft_go: 1'b0, cap_pend: 1'b0, ramp: 32'h0,
                  vid: '{video: VIDEO_MIN, peak: VIDEO_MIN, point_done: 1'b0},
                  pt_cnt: 16'h0, peak_seen: 1'b0, gate: 1'b0, ack: 1'b0,
                  rdata: 32'h0, trig_count: 16'h0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign wb_dat_o       = cur_ff.rdata;
  assign wb_ack_o       = cur_ff.ack;
  assign video_out      = cur_ff.vid.video;
  assign point_peak     = cur_ff.vid.peak;
  assign point_valid    = cur_ff.vid.point_done;
  assign capture_active = cur_ff.capturing;
  assign fft_start      = cur_ff.fft_go;
  assign lo_ramp        = cur_ff.ramp;
  assign gate_open      = cur_ff.gate;

endmodule : time_gate_controller
`default_nettype wire

/* verification/tgc_assertions.sv */
/* Port checks for the time gate controller.
 Bound to every time_gate_controller; single clock mclk. */
`timescale 1ns/1ns
`default_nettype none
module tgc_assertions (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Gate, ramp and video
  input wire logic [31:0] lo_ramp,
  input wire logic        gate_open,
  input wire logic        sweep_restart,
  input wire logic        point_tick,
  input wire logic        point_valid,
  input wire logic [15:0] point_peak,
  // Transform handshake
  input wire logic        fft_start,
  input wire logic        fft_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Ramp holds once the gate has been closed for three cycles
  sequence closed3;
    (!gate_open && !sweep_restart)[*3];
  endsequence
  boot_blocked_a: assert property ($rose(rst_n) |-> !gate_open)
    else $error("gate open right after reset");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  dat_hold_a: assert property (!wb_stb_i |=> $stable(wb_dat_o))
    else $error("read data moved without request");
  ramp_freeze_a: assert property (closed3 |-> $stable(lo_ramp))
    else $error("ramp moved while gate blocked");
  tick_valid_a: assert property (point_tick |=> point_valid)
    else $error("point valid missing");
  valid_cause_a: assert property (point_valid |-> $past(point_tick))
    else $error("point valid without tick");
  peak_grow_a: assert property (!point_tick |=> point_peak >= $past(point_peak))
    else $error("peak fell inside a point");
  fft_pulse_a: assert property (fft_start |-> !$past(fft_busy) ##1 !fft_start)
    else $error("transform start while busy or too long");
endmodule : tgc_assertions
bind time_gate_controller tgc_assertions tgc_assertions_i (.mclk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .lo_ramp, .gate_open, .sweep_restart, .point_tick,
  .point_valid, .point_peak, .fft_start, .fft_busy);
`default_nettype wire

/* verification/fft_path_model.sv */
/* Acquisition path model: takes each transform start, stays busy.
 Assumes fft_start is a one-cycle pulse on mclk. */
`timescale 1ns/1ns
`default_nettype none
module fft_path_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fft_start,
  input wire logic slow,
  output logic     fft_busy,
  output int       starts
);
  int busy_cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 0;
      starts   <= 0;
    end else if (fft_start) begin
      busy_cnt <= slow ? 12 : 1;
      starts   <= starts + 1;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  assign fft_busy = busy_cnt > 0;
endmodule : fft_path_model
`default_nettype wire

/* verification/time_gate_controller_test.sv */
/* Bench for the time gate controller: registers, modes, methods.
 Drives every input but fft_busy itself; fft_path_model answers transform starts. */
`timescale 1ns/1ns
`default_nettype none
module test_time_gate_controller;
  import tgate_pkg::*;
  logic        mclk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF, sel_v = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, lo_ramp, q, step, l = 32'h8E3B;
  logic        gate_trig = 0, point_tick = 0, sweep_restart = 0, slow = 0, wb_ack_o;
  logic [15:0] video_in = 16'h0, video_out, point_peak, mx;
  logic        point_valid, capture_active, fft_start, fft_busy, gate_open;
  logic [16:0] nt, exp_q[$];
  int          err_total, cmp_count, cyc, n_gate, n_cap, starts, t0, lat[2], due_q[$];
  logic [7:0]  ofs_tab[9] = '{OFS_CTRL, OFS_DELAY, OFS_LENGTH, OFS_HOLDOFF, OFS_CAPLEN,
                             OFS_POINTS, OFS_RAMPSTEP, OFS_STATUS, 8'h20};
  logic [31:0] rv_tab[9] = '{CTRL_RST, DELAY_RST, LENGTH_RST, HOLDOFF_RST, CAPLEN_RST,
                            {16'h0, POINTS_RST}, STEP_RST, 32'h0000_0100, 32'h0};
  always #25 mclk = ~mclk;
  time_gate_controller time_gate_controller_i (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gate_trig,
    .video_in, .point_tick, .video_out, .point_peak, .point_valid, .capture_active,
    .fft_start, .fft_busy, .lo_ramp, .sweep_restart, .gate_open);
  fft_path_model fft_path_model_i (.mclk, .rst_n, .fft_start, .slow, .fft_busy, .starts);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, sel_v, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      final_report();
    end else begin
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
    end
  endtask : wb
  task automatic put(input logic s, input logic [15:0] v, input int d);
    exp_q.push_back({s, v});
    due_q.push_back(cyc + d);
  endtask : put
  task automatic sample(input logic open);
    l = nxt(l);
    video_in <= l[15:0];
    put(1'b0, open ? l[15:0] : 16'h0, 1);
    if (open && l[15:0] > mx) mx = l[15:0];
    @(posedge mclk);
  endtask : sample
  // Checks notes whose due cycle has come
  always @(posedge mclk) begin
    #1;
    while (due_q.size() > 0 && due_q[0] == cyc) begin
      void'(due_q.pop_front());
      nt = exp_q.pop_front();
      if (nt[16]) chk("point_peak", 32'(nt[15:0]), 32'(point_peak));
      else chk("video_out", 32'(nt[15:0]), 32'(video_out));
    end
    n_gate += int'(gate_open === 1'b1);
    n_cap += int'(capture_active === 1'b1);
    cyc++;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    wb(1, OFS_STATUS, 32'hFFFF_FFFF);
    wb(1, 8'h20, 32'hFFFF_FFFF);
    foreach (ofs_tab[i]) begin
      wb(0, ofs_tab[i], 32'h0);
      chk("register", rv_tab[i], q);
    end
    sel_v = 4'h1;
    wb(1, OFS_CAPLEN, 32'hABCD_EF04);
    sel_v = 4'hF;
    wb(0, OFS_CAPLEN, 32'h0);
    chk("lane write", 32'h0000_0004, q);
    wb(1, OFS_CTRL, 32'h0000_0010);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      n_gate = 0;
      n_cap = 0;
      t0 = starts;
      gate_trig <= 1'b1;
      repeat (12) @(posedge mclk);
      gate_trig <= 1'b0;
      repeat (30) @(posedge mclk);
      chk("level gate", 12, n_gate);
      chk("capture", 4, n_cap);
      chk("starts", t0 + 1, starts);
    end
    chk("ramp idle", 0, lo_ramp);
    l = nxt(l);
    step = {24'h0, l[7:0]} + 32'h1;
    wb(1, OFS_LENGTH, 32'h0000_0003);
    wb(1, OFS_RAMPSTEP, step);
    wb(1, OFS_CTRL, 32'h0000_0015);
    sweep_restart <= 1'b1;
    @(posedge mclk);
    sweep_restart <= 1'b0;
    for (int d = 0; d < 2; d++) begin
      wb(1, OFS_DELAY, d ? 32'h0000_0005 : 32'h0000_0002);
      n_gate = 0;
      t0 = cyc;
      gate_trig <= 1'b1;
      while (gate_open !== 1'b1 && cyc < t0 + 40) @(posedge mclk);
      lat[d] = cyc - t0;
      gate_trig <= 1'b0;
      repeat (20) @(posedge mclk);
      chk("edge window", 3, n_gate);
    end
    chk("delay step", 3, lat[1] - lat[0]);
    chk("ramp", 6 * step, lo_ramp);
    wb(1, OFS_HOLDOFF, 32'h0000_0014);
    for (int h = 0; h < 2; h++) begin
      wb(1, OFS_CTRL, h ? 32'h0000_0015 : 32'h0000_0017);
      n_gate = 0;
      repeat (6) begin
        gate_trig <= 1'b1;
        repeat (2) @(posedge mclk);
        gate_trig <= 1'b0;
        repeat (2) @(posedge mclk);
      end
      repeat (30) @(posedge mclk);
      chk("retrigger", h, n_gate > 3);
    end
    wb(1, OFS_CTRL, 32'h0000_0018);
    repeat (4) sample(1'b0);
    video_in <= 16'h0;
    gate_trig <= 1'b1;
    repeat (8) @(posedge mclk);
    point_tick <= 1'b1;
    @(posedge mclk);
    point_tick <= 1'b0;
    mx = 16'h0;
    repeat (6) sample(1'b1);
    video_in <= 16'h0;
    repeat (2) @(posedge mclk);
    put(1'b1, mx, 0);
    point_tick <= 1'b1;
    @(posedge mclk);
    point_tick <= 1'b0;
    gate_trig <= 1'b0;
    repeat (10) @(posedge mclk);
    wb(0, OFS_POINTS, 32'h0);
    chk("points", {16'h0002, POINTS_RST}, q);
    final_report();
  end
endmodule : test_time_gate_controller
`default_nettype wire
